/* File: shared/cvc_pkg.sv */
// package: constants and types shared by both ends of the video controller link
package cvc_pkg;
localparam int ADDR_W = 9;
localparam int DATA_W = 24;
localparam int TIM_N = 8;
// word offsets on the link
localparam logic [8:0] OFS_PAL = 9'h000;
localparam logic [8:0] OFS_TIM = 9'h120;
localparam logic [8:0] OFS_LEAD = 9'h121;
localparam logic [8:0] OFS_MASK = 9'h140;
localparam logic [8:0] OFS_CTRL = 9'h160;
localparam logic [8:0] OFS_BOOT = 9'h1a0;
// field positions
localparam int CTRL_VTG = 0;
localparam int CTRL_DIRECT = 1;
localparam int CTRL_ILACE = 2;
localparam int CTRL_BYTE = 7;
localparam int CTRL_DEPTH = 17;
localparam int CTRL_STEP = 19;
localparam int BOOT_PLL = 5;
// reset values
localparam logic [23:0] CTRL_RST = 24'h000000;
localparam logic [23:0] BOOT_RST = 24'h000000;
localparam logic [1:0] LAST_BYTE = 2'h2;
typedef enum logic [1:0] {
    DEPTH_1 = 2'h0,
    DEPTH_2 = 2'h1,
    DEPTH_4 = 2'h2,
    DEPTH_8 = 2'h3
} cvc_depth_t;
typedef logic [15:0] cvc_step_t;
// index is {interlace, bits 20:19}
localparam cvc_step_t STEP_TAB [8] = '{16'h0100, 16'h0200, 16'h0400, 16'h0800,
                                       16'h1000, 16'h2000, 16'h4000, 16'h8000};
// host command port offsets and bits
localparam logic [1:0] HOFS_ADDR = 2'h0;
localparam logic [1:0] HOFS_DATA = 2'h1;
localparam logic [1:0] HOFS_CMD = 2'h2;
localparam logic [1:0] HOFS_STAT = 2'h3;
localparam int CMD_WR = 0;
localparam int CMD_RD = 1;
localparam int STAT_BUSY = 0;
localparam int STAT_BYTE = 1;
localparam int STAT_VTG = 2;
localparam int STAT_BOOT = 3;
localparam int STAT_ERR = 4;
typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_STROBE = 2'b01,
    H_CAPT = 2'b11
} cvc_hstate_t;
endpackage : cvc_pkg

/* File: shared/cvc_if.sv */
// interface: register link between host and video controller
`timescale 1ns/1ps
`default_nettype none
interface cvc_if
    import cvc_pkg::*;
();
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
    logic [DATA_W-1:0] rdata;
    modport dev (input addr, input wdata, input wr, input rd, output rdata);
    modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : cvc_if
`default_nettype wire

/* File: src/cvc_byte_asm.sv */
// module: byte mode assembler that turns byte accesses into word accesses
`timescale 1ns/1ps
`default_nettype none
module cvc_byte_asm
    import cvc_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    // raw link access
    input wire logic byte_mode,
    input wire logic acc_wr,
    input wire logic acc_rd,
    input wire logic [ADDR_W-1:0] acc_addr,
    input wire logic [DATA_W-1:0] acc_data,
    // word access
    output logic word_wr,
    output logic word_rd,
    output logic [DATA_W-1:0] word_data,
    output logic [1:0] byte_sel
);
    logic [1:0] cnt;
    logic [ADDR_W-1:0] last_addr;
    logic [15:0] lo;
    logic restart;
    logic [1:0] cur;

    // a new address starts the sequence again; partial bytes are dropped
    assign restart = (acc_addr != last_addr);
    assign cur = restart ? 2'h0 : cnt;

    // byte counter and address tracking
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt <= 2'h0;
            last_addr <= '0;
        end else if (ce) begin
            if (!byte_mode) begin
                cnt <= 2'h0;
            end else if (acc_wr || acc_rd) begin
                last_addr <= acc_addr;
                cnt <= (cur == LAST_BYTE) ? 2'h0 : cur + 2'h1;
            end
        end
    end

    // low two bytes wait here until the third arrives
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lo <= 16'h0000;
        end else if (ce && byte_mode && acc_wr) begin
            if (cur == 2'h0) begin
                lo[7:0] <= acc_data[7:0];
            end
            if (cur == 2'h1) begin
                lo[15:8] <= acc_data[7:0];
            end
        end
    end

    // nothing reaches the register until all three bytes are in
    assign word_wr = byte_mode ? (acc_wr && cur == LAST_BYTE) : acc_wr;
    assign word_rd = acc_rd;
    assign word_data = byte_mode ? {acc_data[7:0], lo} : acc_data;
    assign byte_sel = byte_mode ? cur : 2'h0;
endmodule : cvc_byte_asm
`default_nettype wire

/* File: src/cvc_device.sv */
// module: video controller end with registers, palette and pixel lookup
`timescale 1ns/1ps
`default_nettype none
module cvc_device
    import cvc_pkg::*;
(
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CE,
    // register link
    cvc_if.dev LINK,
    // pixel stream in
    input wire logic [23:0] PIX_DATA,
    input wire logic PIX_VALID,
    output logic PIX_READY,
    // colour stream out
    output logic [23:0] RGB,
    output logic RGB_VALID,
    // timing and clock control
    output logic VTG_EN,
    output logic BOOT_DONE,
    output logic PLL_EN,
    output logic [4:0] PLL_MULT,
    output logic [15:0] STEP_INC,
    output logic [23:0] SHIFT_LEAD
);
    logic [23:0] device_control;
    logic [7:0] pixel_mask;
    logic [23:0] boot;
    logic boot_done;
    logic [23:0] tim [TIM_N];
    logic [23:0] pal [256];
    logic word_wr;
    logic word_rd;
    logic [23:0] word_data;
    logic [1:0] byte_sel;
    logic byte_mode;
    logic [23:0] rd_word;
    logic [7:0] rd_byte;
    logic is_pal;
    logic is_tim;
    cvc_depth_t depth;
    logic direct;
    logic video_timing_generator;
    logic [2:0] pos;
    logic [3:0] nb;
    logic [7:0] fmask;
    logic [3:0] pos_sum;
    logic last;
    logic take;
    logic [7:0] fld;
    logic [7:0] idx;

    // control fields
    assign byte_mode = device_control[CTRL_BYTE];
    assign video_timing_generator = device_control[CTRL_VTG];
    assign direct = device_control[CTRL_DIRECT];
    assign depth = cvc_depth_t'(device_control[CTRL_DEPTH+1:CTRL_DEPTH]);
    assign is_pal = (LINK.addr[8] == OFS_PAL[8]);
    assign is_tim = (LINK.addr[8:3] == OFS_TIM[8:3]);

    // byte mode front end
    cvc_byte_asm cvc_byte_asm_i (
        .clk(MCLK),
        .rst(RST),
        .ce(CE),
        .byte_mode(byte_mode),
        .acc_wr(LINK.wr),
        .acc_rd(LINK.rd),
        .acc_addr(LINK.addr),
        .acc_data(LINK.wdata),
        .word_wr(word_wr),
        .word_rd(word_rd),
        .word_data(word_data),
        .byte_sel(byte_sel)
    );

    // control register; reset stops the generator and selects word mode
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            device_control <= CTRL_RST;
        end else if (CE && word_wr && LINK.addr == OFS_CTRL) begin
            device_control <= word_data;
        end
    end

    // boot word; later writes are ignored until the next reset
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            boot <= BOOT_RST;
            boot_done <= 1'b0;
        end else if (CE && word_wr && LINK.addr == OFS_BOOT && !boot_done) begin
            boot <= word_data;
            boot_done <= 1'b1;
        end
    end

    // mask, timing and palette keep their contents across reset
    always_ff @(posedge MCLK) begin
        if (CE && word_wr && LINK.addr == OFS_MASK) begin
            pixel_mask <= word_data[7:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (CE && word_wr && is_tim) begin
            tim[LINK.addr[2:0]] <= word_data;
        end
    end

    always_ff @(posedge MCLK) begin
        if (CE && word_wr && is_pal) begin
            pal[LINK.addr[7:0]] <= word_data;
        end
    end

    // read mux; unmapped words read as zero
    always_comb begin
        rd_word = 24'h000000;
        if (is_pal) begin
            rd_word = pal[LINK.addr[7:0]];
        end else if (is_tim) begin
            rd_word = tim[LINK.addr[2:0]];
        end else if (LINK.addr == OFS_MASK) begin
            rd_word = {16'h0000, pixel_mask};
        end else if (LINK.addr == OFS_CTRL) begin
            rd_word = device_control;
        end else if (LINK.addr == OFS_BOOT) begin
            rd_word = boot;
        end
    end

    // byte lane for byte mode reads, low byte first
    always_comb begin
        case (byte_sel)
            2'h0: rd_byte = rd_word[7:0];
            2'h1: rd_byte = rd_word[15:8];
            2'h2: rd_byte = rd_word[23:16];
            default: rd_byte = 8'h00;
        endcase
    end

    // read data stands from the cycle after the strobe until the next read
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            LINK.rdata <= 24'h000000;
        end else if (CE && word_rd) begin
            LINK.rdata <= byte_mode ? {16'h0000, rd_byte} : rd_word;
        end
    end

    // pixel width and field mask per depth
    always_comb begin
        case (depth)
            DEPTH_1: begin
                nb = 4'h1;
                fmask = 8'h01;
            end
            DEPTH_2: begin
                nb = 4'h2;
                fmask = 8'h03;
            end
            DEPTH_4: begin
                nb = 4'h4;
                fmask = 8'h0f;
            end
            DEPTH_8: begin
                nb = 4'h8;
                fmask = 8'hff;
            end
            default: begin
                nb = 4'h8;
                fmask = 8'hff;
            end
        endcase
    end

    // unpacking walks each byte from bit 0 upward
    assign pos_sum = {1'b0, pos} + nb;
    assign last = direct || (pos_sum == 4'h8);
    assign take = video_timing_generator && PIX_VALID;
    assign PIX_READY = video_timing_generator && last;
    assign fld = (PIX_DATA[7:0] >> pos) & fmask;
    // field is only n bits wide, so only the first 2^n entries are hit
    assign idx = fld & pixel_mask;

    // position inside the packed byte
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            pos <= 3'h0;
        end else if (CE) begin
            if (!video_timing_generator) begin
                pos <= 3'h0;
            end else if (take) begin
                pos <= last ? 3'h0 : pos_sum[2:0];
            end
        end
    end

    // palette lookup; one cycle of latency from the accepted pixel
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            RGB <= 24'h000000;
            RGB_VALID <= 1'b0;
        end else if (CE) begin
            RGB_VALID <= take;
            if (take && direct) begin
                RGB <= {pal[PIX_DATA[23:16]][23:16],
                        pal[PIX_DATA[15:8]][15:8],
                        pal[PIX_DATA[7:0]][7:0]};
            end else if (take) begin
                RGB <= pal[idx];
            end
        end
    end

    // step selection registered so it stays glitch free toward memory
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            STEP_INC <= STEP_TAB[0];
        end else if (CE) begin
            STEP_INC <= STEP_TAB[{device_control[CTRL_ILACE],
                                  device_control[CTRL_STEP+1:CTRL_STEP]}];
        end
    end

    // lead value exported to the transfer logic
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            SHIFT_LEAD <= 24'h000000;
        end else if (CE) begin
            SHIFT_LEAD <= tim[OFS_LEAD[2:0]];
        end
    end

    // loop only runs once a boot word is in
    assign VTG_EN = video_timing_generator;
    assign BOOT_DONE = boot_done;
    assign PLL_EN = boot_done && boot[BOOT_PLL];
    assign PLL_MULT = boot[4:0];
endmodule : cvc_device
`default_nettype wire

/* File: src/cvc_host.sv */
// module: host end that issues word or byte link accesses on command
`timescale 1ns/1ps
`default_nettype none
module cvc_host
    import cvc_pkg::*;
(
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    input wire logic CE,
    // software port
    input wire logic [1:0] ADDR,
    input wire logic [23:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [23:0] RDATA,
    // frame flyback from the display side
    input wire logic FLYBACK,
    // register link
    cvc_if.host LINK
);
    cvc_hstate_t state;
    logic [8:0] t_addr;
    logic [23:0] t_data;
    logic is_wr;
    logic [1:0] bcnt;
    logic byte_mode;
    logic vtg_on;
    logic boot_done;
    logic err;
    logic [TIM_N-1:0] tim_set;
    logic go;
    logic is_tim;
    logic refuse;
    logic [7:0] nxt_byte;
    logic [4:0] stat;

    assign go = WR && ADDR == HOFS_CMD && (WDATA[CMD_WR] || WDATA[CMD_RD]);
    assign is_tim = (t_addr[8:3] == OFS_TIM[8:3]);
    // refusal keeps the device from being driven out of order
    assign refuse = (!boot_done && t_addr != OFS_BOOT)
        || (boot_done && t_addr == OFS_BOOT)
        || ((is_tim || t_addr == OFS_MASK) && vtg_on)
        || (t_addr[8] == OFS_PAL[8] && vtg_on && !FLYBACK)
        || (WDATA[CMD_WR] && t_addr == OFS_CTRL && t_data[CTRL_VTG] && !vtg_on
            && tim_set != {TIM_N{1'b1}});
    assign stat = {err, boot_done, vtg_on, byte_mode, state != H_IDLE};
    always_comb begin
        case (bcnt)
            2'h0: nxt_byte = t_data[15:8];
            default: nxt_byte = t_data[23:16];
        endcase
    end

    // software registers and read port, data only in the cycle after
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            t_addr <= 9'h000;
            RDATA <= 24'h000000;
        end else if (CE) begin
            if (WR && ADDR == HOFS_ADDR) begin
                t_addr <= WDATA[8:0];
            end
            RDATA <= 24'h000000;
            if (RD) begin
                case (ADDR)
                    HOFS_ADDR: RDATA <= {15'h0000, t_addr};
                    HOFS_DATA: RDATA <= t_data;
                    HOFS_STAT: RDATA <= {19'h00000, stat};
                    default: RDATA <= 24'h000000;
                endcase
            end
        end
    end

    // access sequencer; one strobe per word, three in byte mode
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state <= H_IDLE;
            t_data <= 24'h000000;
            is_wr <= 1'b0;
            bcnt <= 2'h0;
            err <= 1'b0;
            LINK.addr <= 9'h000;
            LINK.wdata <= 24'h000000;
            LINK.wr <= 1'b0;
            LINK.rd <= 1'b0;
        end else if (CE) begin
            LINK.wr <= 1'b0;
            LINK.rd <= 1'b0;
            case (state)
                H_IDLE: begin
                    if (WR && ADDR == HOFS_DATA) begin
                        t_data <= WDATA;
                    end
                    if (go && refuse) begin
                        err <= 1'b1;
                    end else if (go) begin
                        err <= 1'b0;
                        is_wr <= WDATA[CMD_WR];
                        bcnt <= 2'h0;
                        LINK.addr <= t_addr;
                        LINK.wdata <= byte_mode ? {16'h0000, t_data[7:0]} : t_data;
                        LINK.wr <= WDATA[CMD_WR];
                        LINK.rd <= !WDATA[CMD_WR];
                        state <= H_STROBE;
                    end
                end
                H_STROBE: begin
                    if (!is_wr) begin
                        state <= H_CAPT;
                    end else if (byte_mode && bcnt != LAST_BYTE) begin
                        // same address each time so the device keeps counting
                        LINK.wdata <= {16'h0000, nxt_byte};
                        LINK.wr <= 1'b1;
                        bcnt <= bcnt + 2'h1;
                    end else begin
                        state <= H_IDLE;
                    end
                end
                H_CAPT: begin
                    if (!byte_mode) begin
                        t_data <= LINK.rdata;
                        state <= H_IDLE;
                    end else begin
                        case (bcnt)
                            2'h0: t_data[7:0] <= LINK.rdata[7:0];
                            2'h1: t_data[15:8] <= LINK.rdata[7:0];
                            default: t_data[23:16] <= LINK.rdata[7:0];
                        endcase
                        if (bcnt != LAST_BYTE) begin
                            LINK.rd <= 1'b1;
                            bcnt <= bcnt + 2'h1;
                            state <= H_STROBE;
                        end else begin
                            state <= H_IDLE;
                        end
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    // shadows of device state, taken when a write completes
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            byte_mode <= 1'b0;
            vtg_on <= 1'b0;
            boot_done <= 1'b0;
            tim_set <= '0;
        end else if (CE && state == H_STROBE && is_wr
                     && (!byte_mode || bcnt == LAST_BYTE)) begin
            if (LINK.addr == OFS_CTRL) begin
                byte_mode <= t_data[CTRL_BYTE];
                vtg_on <= t_data[CTRL_VTG];
            end
            if (LINK.addr == OFS_BOOT) begin
                boot_done <= 1'b1;
            end
            if (LINK.addr[8:3] == OFS_TIM[8:3]) begin
                tim_set[LINK.addr[2:0]] <= (t_data != 24'h000000);
            end
        end
    end
endmodule : cvc_host
`default_nettype wire

/* File: verification/cvc_link_chk.sv */
// checker: link protocol and device output relations
`timescale 1ns/1ps
`default_nettype none
module cvc_link_chk
    import cvc_pkg::*;
(
    // clock and reset
    input wire logic MCLK,
    input wire logic RST,
    // link signals
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [DATA_W-1:0] rdata,
    // device outputs and the pixel valid input
    input wire logic VTG_EN,
    input wire logic BOOT_DONE,
    input wire logic PLL_EN,
    input wire logic PIX_VALID,
    input wire logic RGB_VALID,
    input wire logic [15:0] STEP_INC
);
    // loop bit of the data bus, kept apart so it can be sampled
    logic pll_bit;
    assign pll_bit = wdata[BOOT_PLL];
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);
    a_strobe_excl: assert property (!(wr && rd))
        else $error("link write and read together");
    a_boot_first: assert property (!BOOT_DONE && wr |-> addr == OFS_BOOT)
        else $error("write before boot word");
    a_boot_take: assert property ($rose(BOOT_DONE) |->
        $past(wr) && $past(addr) == OFS_BOOT && PLL_EN == $past(pll_bit))
        else $error("boot word not taken as written");
    a_boot_held: assert property (BOOT_DONE |=> BOOT_DONE)
        else $error("boot flag dropped without reset");
    a_vtg_cause: assert property ($changed(VTG_EN) |->
        $past(wr) && $past(addr) == OFS_CTRL)
        else $error("generator changed without control write");
    a_rst_clear: assert property ($fell(RST) |-> !VTG_EN && !BOOT_DONE)
        else $error("reset left generator or boot set");
    a_step_cause: assert property ($changed(STEP_INC) |->
        ($past(wr, 2) && $past(addr, 2) == OFS_CTRL)
        || ($past(wr) && $past(addr) == OFS_CTRL))
        else $error("address step changed without control write");
    a_rdata_hold: assert property (!rd |=> $stable(rdata))
        else $error("read data moved without read");
    a_pix_take: assert property (VTG_EN && PIX_VALID |=> RGB_VALID)
        else $error("pixel taken without colour out");
    a_pix_idle: assert property (!VTG_EN |=> !RGB_VALID)
        else $error("colour out while generator off");
endmodule : cvc_link_chk
`default_nettype wire

/* File: verification/video_controller_host_config_test.sv */
// testbench: host and device ends joined by the link
`timescale 1ns/1ps
`default_nettype none
module video_controller_host_config_test;
    import cvc_pkg::*;
    logic clk, rst, ce, wr, rd, fb, pvld, prdy, rgbv, video_timing_generator, bootd, pll;
    logic [1:0] adr;
    logic [23:0] wd, rdat, pd, rgb, lead, v;
    logic [4:0] mult;
    logic [15:0] step;
    int err_total, total_checks;
    cvc_if lnk_if();
    cvc_host cvc_host_i(.MCLK(clk), .RST(rst), .CE(ce), .ADDR(adr), .WDATA(wd), .WR(wr),
        .RD(rd), .RDATA(rdat), .FLYBACK(fb), .LINK(lnk_if));
    cvc_device cvc_device_i(.MCLK(clk), .RST(rst), .CE(ce), .LINK(lnk_if), .PIX_DATA(pd),
        .PIX_VALID(pvld), .PIX_READY(prdy), .RGB(rgb), .RGB_VALID(rgbv), .VTG_EN(video_timing_generator),
        .BOOT_DONE(bootd), .PLL_EN(pll), .PLL_MULT(mult), .STEP_INC(step), .SHIFT_LEAD(lead));
    cvc_link_chk cvc_link_chk_i(.MCLK(clk), .RST(rst), .addr(lnk_if.addr),
        .wdata(lnk_if.wdata), .wr(lnk_if.wr), .rd(lnk_if.rd), .rdata(lnk_if.rdata),
        .VTG_EN(video_timing_generator), .BOOT_DONE(bootd), .PLL_EN(pll), .PIX_VALID(pvld), .RGB_VALID(rgbv),
        .STEP_INC(step));
    // free-running 125 MHz clock
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // palette fill pattern, non-zero in every field for the indices written here (0 to 15 and e4)
    function automatic logic [23:0] pal(input logic [7:0] i);
        return {i ^ 8'h5a, i ^ 8'ha5, i + 8'h11};
    endfunction : pal
    task automatic test_done;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : test_done
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] s);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("wrong value %s exp %h got %h", n, e, s);
        end
    endtask : chk
    // software port: one-cycle strobes after the edge
    task automatic sw_wr(input logic [1:0] a, input logic [23:0] d);
        @(posedge clk);
        adr <= a;
        wd <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : sw_wr
    task automatic sw_rd(input logic [1:0] a, output logic [23:0] d);
        @(posedge clk);
        adr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
        d = rdat;
    endtask : sw_rd
    // one link command, polled to completion; e is the expected refusal flag
    task automatic op(input logic [8:0] a, input logic [23:0] d, input logic [1:0] c,
        input logic e);
        logic [23:0] st;
        int n;
        sw_wr(HOFS_ADDR, 24'(a));
        sw_wr(HOFS_DATA, d);
        sw_wr(HOFS_CMD, 24'(c));
        n = 0;
        st = 24'h1;
        while (n == 0 || st[STAT_BUSY] !== 1'b0) begin
            n++;
            if (n > 40) begin
                err_total++;
                $display("wrong value busy exp 0 got 1");
                test_done();
            end
            sw_rd(HOFS_STAT, st);
        end
        chk("err", 24'(e), 24'(st[STAT_ERR]));
    endtask : op
    task automatic rdw(input logic [8:0] a, output logic [23:0] d);
        op(a, 24'h0, 2'h2, 1'b0);
        sw_rd(HOFS_DATA, d);
    endtask : rdw
    // one pixel byte or word; b is bits per pixel, 24 for direct
    task automatic pix(input logic [23:0] p, input int b, input logic [7:0] m);
        int n;
        logic [7:0] ix;
        logic [23:0] e;
        n = (b == 24) ? 1 : 8 / b;
        @(posedge clk);
        pd <= p;
        pvld <= 1'b1;
        // ready before the first take: only whole-byte or direct pixels finish at once
        @(negedge clk);
        chk("ready", 24'(n == 1), 24'(prdy));
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            if (k == n - 1) pvld <= 1'b0;
            @(negedge clk);
            ix = 8'((p[7:0] >> (k * b)) & ((1 << b) - 1)) & m;
            e = pal(ix);
            if (b == 24) e = (pal(p[23:16]) & 24'hff0000) | (pal(p[15:8]) & 24'h00ff00)
                | (pal(p[7:0]) & 24'h0000ff);
            chk("rgb_valid", 24'h1, 24'(rgbv));
            chk("rgb", e, rgb);
        end
    endtask : pix
    // main sequence
    initial begin
        err_total = 0;
        total_checks = 0;
        {rst, wr, rd, fb, pvld, adr, wd, pd} = {1'b1, 54'h0};
        ce = 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("vtg", 24'h0, 24'(video_timing_generator));
        chk("step", 24'h100, 24'(step));
        op(OFS_CTRL, 24'h0, 2'h1, 1'b1);
        op(OFS_BOOT, 24'h27, 2'h1, 1'b0);
        chk("pll", 24'h1, 24'(pll));
        op(OFS_BOOT, 24'h03, 2'h1, 1'b1);
        chk("mult", 24'h7, 24'(mult));
        op(OFS_CTRL, 24'h0, 2'h1, 1'b0);
        op(OFS_CTRL, 24'h1, 2'h1, 1'b1);
        for (int i = 0; i < 8; i++) begin
            op(OFS_TIM + 9'(i), (i == 1) ? 24'h000012 : 24'(i + 3), 2'h1, 1'b0);
        end
        chk("lead", 24'h000012, lead);
        op(OFS_MASK, 24'h1234ff, 2'h1, 1'b0);
        for (int i = 0; i < 17; i++) begin
            op((i == 16) ? 9'h0e4 : 9'(i), pal((i == 16) ? 8'he4 : 8'(i)), 2'h1, 1'b0);
        end
        for (int s = 0; s < 8; s++) begin
            op(OFS_CTRL, (24'(s & 3) << 19) | (24'(s >> 2) << 2), 2'h1, 1'b0);
            chk("step", 24'(16'h0100 << s), 24'(step));
        end
        for (int d = 0; d < 4; d++) begin
            op(OFS_CTRL, 24'h0, 2'h1, 1'b0);
            op(OFS_CTRL, (24'(d) << 17) | 24'h1, 2'h1, 1'b0);
            chk("vtg", 24'h1, 24'(video_timing_generator));
            pix(24'h0000e4, 1 << d, 8'hff);
        end
        op(OFS_TIM, 24'h5, 2'h1, 1'b1);
        op(OFS_MASK, 24'h0f, 2'h1, 1'b1);
        op(9'h010, pal(8'h10), 2'h1, 1'b1);
        @(posedge clk);
        fb <= 1'b1;
        op(9'h010, pal(8'h10), 2'h1, 1'b0);
        @(posedge clk);
        fb <= 1'b0;
        op(OFS_CTRL, 24'h0, 2'h1, 1'b0);
        op(OFS_MASK, 24'habcd0f, 2'h1, 1'b0);
        op(OFS_CTRL, 24'h060001, 2'h1, 1'b0);
        pix(24'h0000e4, 8, 8'h0f);
        op(OFS_CTRL, 24'h0, 2'h1, 1'b0);
        op(OFS_MASK, 24'hff, 2'h1, 1'b0);
        op(OFS_CTRL, 24'h060003, 2'h1, 1'b0);
        pix(24'h010203, 24, 8'hff);
        op(OFS_CTRL, 24'h0, 2'h1, 1'b0);
        op(OFS_CTRL, 24'h80, 2'h1, 1'b0);
        op(OFS_TIM + 9'h7, 24'h345678, 2'h1, 1'b0);
        rdw(OFS_TIM + 9'h7, v);
        chk("byte_rd", 24'h345678, v);
        // second reset in mid-run: contents kept, boot needed again
        @(posedge clk);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(negedge clk);
        chk("boot", 24'h0, 24'(bootd));
        op(OFS_BOOT, 24'h07, 2'h1, 1'b0);
        chk("pll", 24'h0, 24'(pll));
        rdw(9'h005, v);
        chk("pal", pal(8'h05), v);
        rdw(OFS_TIM + 9'h7, v);
        chk("tim", 24'h345678, v);
        // clock enable low: a software write must leave the address register alone
        @(posedge clk);
        ce <= 1'b0;
        sw_wr(HOFS_ADDR, 24'h0000ab);
        ce <= 1'b1;
        sw_rd(HOFS_ADDR, v);
        chk("ce_hold", 24'h000127, v);
        test_done();
    end
endmodule : video_controller_host_config_test
`default_nettype wire
